//--- hdl/phy_ctrl_regs.svh
// constants for the mii duplex and auto-negotiation control block
// assumes clk at 250 MHz and a line clock of its own for the receive side
//
// Notes on behaviour
// - negotiation enable comes from pin or soft bit
// - negotiate, then take best common mode
// - 100M: 4B/5B, scrambler, nrzi, mlt-3 serial line
// - 10M: serial line with manchester coding
// - 10M full duplex: no loopback, no sqe test
// - full duplex: carrier from receive only, no collision
// - half duplex: carrier on transmit or receive
// - half duplex: collision when receiving while transmitting
// - mii carries framed nibbles with enable, valid, error
// - phy drives both mii clocks
// - mii rate follows line speed, 10 or 100
// - isolate mii and line driver during reset
// - enable mii and line driver after reset
// - both duplex modes at both speeds
`ifndef PHY_CTRL_REGS_SVH
`define PHY_CTRL_REGS_SVH

// =====================================================================
// clocking
`define CLK_FREQ_MHZ 250
`define CLK_PERIOD_NS 4
`define MII_RATE_100_KHZ 25000
`define MII_RATE_10_KHZ 2500
`define MII_HALF_100 (`CLK_FREQ_MHZ * 1000 / (2 * `MII_RATE_100_KHZ))
`define MII_HALF_10 (`CLK_FREQ_MHZ * 1000 / (2 * `MII_RATE_10_KHZ))
`define BIT_CYC_100 (2 * `MII_HALF_100 / 5)
`define BIT_CYC_10 (2 * `MII_HALF_10 / 4)
`define MAN_HALF_CYC (`BIT_CYC_10 / 2)

// =====================================================================
// timing
`define POR_HOLD_NS 20000
`define POR_HOLD_CYC (`POR_HOLD_NS / `CLK_PERIOD_NS)
`define SQE_WAIT_NS 1000
`define SQE_WAIT_CYC ((`SQE_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SQE_LEN_NS 1000
`define SQE_LEN_CYC (`SQE_LEN_NS / `CLK_PERIOD_NS)

// =====================================================================
// ability bits and line symbols
`define ABIL_10HD 0
`define ABIL_10FD 1
`define ABIL_100HD 2
`define ABIL_100FD 3
`define LOCAL_ABIL_DEFAULT 4'hf
`define SYM_J 5'h18
`define SYM_K 5'h11
`define SYM_T 5'h0d
`define SYM_R 5'h07
`define SYM_I 5'h1f
`define SYM_H 5'h04
`define SCR_SEED 11'h7ff
`define PREAMBLE_NIB 4'h5

`endif

//--- hdl/phy_pkg.sv
// types and 4B/5B code tables for the phy control block
// assumes nothing beyond the constants header
`default_nettype none
package phy_pkg;

  typedef struct packed {
    logic speed100;
    logic full_duplex;
  } link_mode_t;

  typedef struct packed {
    logic config_source_select;
    logic autoneg_select_pin;
    logic sw_autoneg_enable;
    logic hw_speed100;
    logic hw_full_duplex;
    logic sw_speed100;
    logic sw_full_duplex;
    logic partner_valid;
    logic [3:0] partner_abilities;
  } cfg_pins_t;

  typedef struct packed {
    logic [3:0] txd;
    logic tx_en;
    logic tx_er;
  } mii_tx_t;

  typedef struct packed {
    logic err;
    logic [3:0] data;
  } rx_word_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_K = 2'b01,
    TX_DATA = 2'b11,
    TX_R = 2'b10
  } tx_state_t;

  localparam logic [4:0] CODE_TABLE [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d
  };

  function automatic logic [4:0] enc_4b5b(input logic [3:0] nib);
    return CODE_TABLE[nib];
  endfunction : enc_4b5b

  // returns {valid, nibble}
  function automatic logic [4:0] dec_5b4b(input logic [4:0] sym);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (CODE_TABLE[i] == sym) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : dec_5b4b

endpackage : phy_pkg
`default_nettype wire

//--- hdl/word_crossing.sv
// toggle handshake carrying one word per event between clock domains
// assumes source events spaced by at least four destination cycles
`default_nettype none
module word_crossing #(
  parameter int WIDTH = 5
) (
  // source side
  input wire logic src_clk,
  input wire logic src_arst_n,
  input wire logic src_evt,
  input wire logic [WIDTH-1:0] src_word,
  // destination side
  input wire logic dst_clk,
  input wire logic dst_arst_n,
  output logic dst_evt,
  output logic [WIDTH-1:0] dst_word
);

  logic src_toggle;
  logic [WIDTH-1:0] src_hold;
  logic [2:0] dst_sync;

  always_ff @(posedge src_clk or negedge src_arst_n) begin
    if (!src_arst_n) begin
      src_toggle <= 1'b0;
      src_hold <= '0;
    end else if (src_evt) begin
      src_toggle <= ~src_toggle;
      src_hold <= src_word;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_arst_n) begin
    if (!dst_arst_n) begin
      dst_sync <= 3'h0;
      dst_evt <= 1'b0;
      dst_word <= '0;
    end else begin
      dst_sync <= {dst_sync[1:0], src_toggle};
      dst_evt <= dst_sync[2] ^ dst_sync[1];
      if (dst_sync[2] ^ dst_sync[1]) begin
        dst_word <= src_hold;
      end
    end
  end

endmodule : word_crossing
`default_nettype wire

//--- hdl/line_rx_decoder.sv
// receive line decoder on the recovered line clock
// assumes one line level per edge: one mlt-3 level or one manchester half bit
`default_nettype none
`include "phy_ctrl_regs.svh"
module line_rx_decoder (
  // line side
  input wire logic line_clk,
  input wire logic arst_n,
  input wire logic line_rx_positive,
  input wire logic line_rx_negative,
  // control from the system domain
  input wire logic speed100,
  // decoded output
  output logic word_evt,
  output phy_pkg::rx_word_t word,
  output logic active
);

  logic [1:0] spd_sync;
  logic [1:0] prev_lvl;
  logic [10:0] lfsr;
  logic [9:0] win;
  logic [2:0] sym_cnt;
  logic half;
  logic first_half;
  logic [1:0] bit_cnt;
  logic [3:0] nib;
  logic err_acc;
  logic scr_bit;
  logic fb;
  logic [9:0] next_win;
  logic [4:0] dec;

  assign scr_bit = ({line_rx_positive, line_rx_negative} != prev_lvl);
  assign fb = lfsr[10] ^ lfsr[8];
  assign next_win = {win[8:0], scr_bit ^ fb};
  assign dec = phy_pkg::dec_5b4b(next_win[4:0]);

  // mlt-3 level step and self-synchronising descrambler
  always_ff @(posedge line_clk or negedge arst_n) begin
    if (!arst_n) begin
      spd_sync <= 2'h0;
      prev_lvl <= 2'h0;
      lfsr <= `SCR_SEED;
      win <= 10'h000;
    end else begin
      spd_sync <= {spd_sync[0], speed100};
      prev_lvl <= {line_rx_positive, line_rx_negative};
      lfsr <= {lfsr[9:0], active ? fb : ~scr_bit};
      win <= next_win;
    end
  end

  // framing and symbol or manchester decode
  always_ff @(posedge line_clk or negedge arst_n) begin
    if (!arst_n) begin
      active <= 1'b0;
      word_evt <= 1'b0;
      word <= '0;
      sym_cnt <= 3'h0;
      half <= 1'b0;
      first_half <= 1'b0;
      bit_cnt <= 2'h0;
      nib <= 4'h0;
      err_acc <= 1'b0;
    end else begin
      word_evt <= 1'b0;
      if (spd_sync[1]) begin
        if (!active) begin
          if (next_win == {`SYM_J, `SYM_K}) begin
            active <= 1'b1;
            sym_cnt <= 3'h0;
            word_evt <= 1'b1;
            word <= {1'b0, `PREAMBLE_NIB};
          end
        end else if (sym_cnt == 3'h4) begin
          sym_cnt <= 3'h0;
          if (next_win[4:0] == `SYM_T || next_win[4:0] == `SYM_I) begin
            active <= 1'b0;
          end else begin
            word_evt <= 1'b1;
            word <= {~dec[4], dec[3:0]};
          end
        end else begin
          sym_cnt <= sym_cnt + 3'h1;
        end
      end else if (!(line_rx_positive ^ line_rx_negative)) begin
        active <= 1'b0;
        half <= 1'b0;
        bit_cnt <= 2'h0;
        err_acc <= 1'b0;
      end else begin
        active <= 1'b1;
        half <= ~half;
        if (!half) begin
          first_half <= line_rx_positive;
        end else begin
          nib <= {line_rx_positive, nib[3:1]};
          bit_cnt <= bit_cnt + 2'h1;
          err_acc <= 1'b0;
          if (bit_cnt == 2'h3) begin
            word_evt <= 1'b1;
            word <= {err_acc | (line_rx_positive == first_half), line_rx_positive, nib[3:1]};
          end else begin
            err_acc <= err_acc | (line_rx_positive == first_half);
          end
        end
      end
    end
  end

endmodule : line_rx_decoder
`default_nettype wire

//--- hdl/phy_mii_duplex_autoneg_ctrl.sv
// mii side control of a 10/100 phy: mode choice, line coding, carrier,
// collision, loopback, sqe test and reset isolation
// assumes mii and config pins asynchronous to clk; line_clk is the
// recovered receive clock of the line
`default_nettype none
`include "phy_ctrl_regs.svh"
module phy_mii_duplex_autoneg_ctrl #(
  parameter int POR_HOLD_CYCLES = `POR_HOLD_CYC,
  parameter logic [3:0] LOCAL_ABILITIES = `LOCAL_ABIL_DEFAULT
) (
  // system
  input wire logic clk,
  input wire logic arst_n,
  // configuration pins and soft inputs
  input wire phy_pkg::cfg_pins_t cfg_in,
  // mii transmit from the mac
  input wire phy_pkg::mii_tx_t mii_tx,
  // mii outputs to the mac
  output logic mii_tx_clk,
  output logic mii_rx_clk,
  output logic [3:0] mii_rxd,
  output logic mii_rx_dv,
  output logic mii_rx_er,
  output logic mii_crs,
  output logic mii_col,
  output logic mii_oe,
  // line
  input wire logic line_clk,
  input wire logic line_rx_positive,
  input wire logic line_rx_negative,
  output logic line_tx_positive,
  output logic line_tx_negative,
  output logic line_tx_oe,
  // status
  output logic autoneg_enabled,
  output logic link_speed100,
  output logic link_full_duplex
);

  localparam int POR_W = $clog2(POR_HOLD_CYCLES + 1);
  localparam logic [6:0] HALF100_M1 = 7'(`MII_HALF_100 - 1);
  localparam logic [6:0] HALF10_M1 = 7'(`MII_HALF_10 - 1);
  localparam logic [4:0] BIT100_M1 = 5'(`BIT_CYC_100 - 1);
  localparam logic [4:0] BIT10_M1 = 5'(`BIT_CYC_10 - 1);
  localparam logic [4:0] MAN_MID = 5'(`MAN_HALF_CYC);
  localparam logic [8:0] SQE_WAIT = 9'(`SQE_WAIT_CYC);
  localparam logic [8:0] SQE_END = 9'(`SQE_WAIT_CYC + `SQE_LEN_CYC);

  // =====================================================================
  // input synchronisers

  phy_pkg::cfg_pins_t cfg_meta;
  phy_pkg::cfg_pins_t cfg;
  phy_pkg::mii_tx_t tx_meta;
  phy_pkg::mii_tx_t tx_s;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_meta <= '0;
      cfg <= '0;
      tx_meta <= '0;
      tx_s <= '0;
    end else begin
      cfg_meta <= cfg_in;
      cfg <= cfg_meta;
      tx_meta <= mii_tx;
      tx_s <= tx_meta;
    end
  end

  // =====================================================================
  // reset isolation

  logic [POR_W-1:0] por_cnt;
  logic iso;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      por_cnt <= '0;
      iso <= 1'b1;
    end else if (iso) begin
      if (por_cnt == POR_W'(POR_HOLD_CYCLES - 1)) begin
        iso <= 1'b0;
      end else begin
        por_cnt <= por_cnt + POR_W'(1);
      end
    end
  end

  // =====================================================================
  // mode selection

  phy_pkg::link_mode_t mode;
  phy_pkg::link_mode_t forced_mode;
  logic next_an_en;
  logic [3:0] common;

  function automatic phy_pkg::link_mode_t best_mode(input logic [3:0] abil);
    phy_pkg::link_mode_t m;
    m = '0;
    if (abil[`ABIL_100FD]) begin
      m = '{speed100: 1'b1, full_duplex: 1'b1};
    end else if (abil[`ABIL_100HD]) begin
      m = '{speed100: 1'b1, full_duplex: 1'b0};
    end else if (abil[`ABIL_10FD]) begin
      m = '{speed100: 1'b0, full_duplex: 1'b1};
    end
    return m;
  endfunction : best_mode

  // low selects the pins, high the soft inputs
  assign next_an_en = cfg.config_source_select ? cfg.sw_autoneg_enable
                                               : cfg.autoneg_select_pin;
  assign forced_mode = cfg.config_source_select ?
                       {cfg.sw_speed100, cfg.sw_full_duplex} :
                       {cfg.hw_speed100, cfg.hw_full_duplex};
  assign common = LOCAL_ABILITIES & cfg.partner_abilities;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= '0;
      autoneg_enabled <= 1'b0;
      link_speed100 <= 1'b0;
      link_full_duplex <= 1'b0;
    end else begin
      autoneg_enabled <= next_an_en;
      if (!next_an_en) begin
        mode <= forced_mode;
      end else if (cfg.partner_valid) begin
        mode <= best_mode(common);
      end
      link_speed100 <= mode.speed100;
      link_full_duplex <= mode.full_duplex;
    end
  end

  // =====================================================================
  // mii clock divider

  logic [6:0] div_cnt;
  logic clk_level;
  logic wrap;
  logic nib_tick;

  assign wrap = (div_cnt >= (mode.speed100 ? HALF100_M1 : HALF10_M1));
  // falling edge: data from the mac has settled, receive data may change
  assign nib_tick = wrap & clk_level;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 7'h00;
      clk_level <= 1'b0;
      mii_tx_clk <= 1'b0;
      mii_rx_clk <= 1'b0;
    end else begin
      div_cnt <= wrap ? 7'h00 : div_cnt + 7'h01;
      if (wrap) begin
        clk_level <= ~clk_level;
      end
      mii_tx_clk <= ~iso & (wrap ? ~clk_level : clk_level);
      mii_rx_clk <= ~iso & (wrap ? ~clk_level : clk_level);
    end
  end

  // =====================================================================
  // transmit framing

  phy_pkg::tx_state_t tx_state;
  phy_pkg::tx_state_t next_tx_state;
  logic [4:0] next_sym;

  always_comb begin
    next_tx_state = tx_state;
    next_sym = `SYM_I;
    unique case (tx_state)
      phy_pkg::TX_IDLE: begin
        if (tx_s.tx_en) begin
          next_sym = `SYM_J;
          next_tx_state = phy_pkg::TX_K;
        end
      end
      phy_pkg::TX_K: begin
        next_sym = `SYM_K;
        next_tx_state = phy_pkg::TX_DATA;
      end
      phy_pkg::TX_DATA: begin
        if (!tx_s.tx_en) begin
          next_sym = `SYM_T;
          next_tx_state = phy_pkg::TX_R;
        end else if (tx_s.tx_er) begin
          next_sym = `SYM_H;
        end else begin
          next_sym = phy_pkg::enc_4b5b(tx_s.txd);
        end
      end
      phy_pkg::TX_R: begin
        next_sym = `SYM_R;
        next_tx_state = phy_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state <= phy_pkg::TX_IDLE;
    end else if (!mode.speed100) begin
      tx_state <= phy_pkg::TX_IDLE;
    end else if (nib_tick) begin
      tx_state <= next_tx_state;
    end
  end

  // =====================================================================
  // bit timing and serialiser

  logic [4:0] bit_cnt;
  logic bit_last;
  logic bit_start;
  logic [4:0] shreg;
  logic cur_bit;
  logic man_en;

  assign bit_last = (bit_cnt >= (mode.speed100 ? BIT100_M1 : BIT10_M1));
  assign bit_start = nib_tick | bit_last;
  assign cur_bit = nib_tick ? (mode.speed100 ? next_sym[4] : tx_s.txd[0])
                            : (mode.speed100 ? shreg[3] : shreg[1]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 5'h00;
      shreg <= 5'h00;
      man_en <= 1'b0;
    end else begin
      bit_cnt <= bit_start ? 5'h00 : bit_cnt + 5'h01;
      if (nib_tick) begin
        shreg <= mode.speed100 ? next_sym : {1'b0, tx_s.txd};
        man_en <= tx_s.tx_en & ~mode.speed100;
      end else if (bit_start) begin
        shreg <= mode.speed100 ? {shreg[3:0], 1'b0} : {1'b0, shreg[4:1]};
      end
    end
  end

  // =====================================================================
  // line coding and drive

  logic [10:0] lfsr;
  logic [1:0] mlt_phase;
  logic [1:0] next_phase;
  logic fb;
  logic man_bit;

  assign fb = lfsr[10] ^ lfsr[8];
  // a scrambled one is an nrzi transition, which steps the mlt-3 level
  assign next_phase = mlt_phase + {1'b0, cur_bit ^ fb};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lfsr <= `SCR_SEED;
      mlt_phase <= 2'h0;
      man_bit <= 1'b0;
      line_tx_positive <= 1'b0;
      line_tx_negative <= 1'b0;
      line_tx_oe <= 1'b0;
    end else begin
      line_tx_oe <= ~iso;
      if (iso) begin
        line_tx_positive <= 1'b0;
        line_tx_negative <= 1'b0;
      end else if (mode.speed100) begin
        if (bit_start) begin
          lfsr <= {lfsr[9:0], fb};
          mlt_phase <= next_phase;
          line_tx_positive <= (next_phase == 2'h1);
          line_tx_negative <= (next_phase == 2'h3);
        end
      end else if (bit_start) begin
        man_bit <= cur_bit;
        line_tx_positive <= man_en & ~cur_bit;
        line_tx_negative <= man_en & cur_bit;
      end else if (bit_cnt == MAN_MID) begin
        line_tx_positive <= man_en & man_bit;
        line_tx_negative <= man_en & ~man_bit;
      end
    end
  end

  // =====================================================================
  // sqe test

  logic tx_prev;
  logic [8:0] sqe_cnt;
  logic sqe_run;
  logic sqe_on;

  assign sqe_on = sqe_run & (sqe_cnt >= SQE_WAIT);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_prev <= 1'b0;
      sqe_cnt <= 9'h000;
      sqe_run <= 1'b0;
    end else begin
      tx_prev <= tx_s.tx_en;
      if (tx_prev & ~tx_s.tx_en & ~mode.speed100 & ~mode.full_duplex) begin
        sqe_run <= 1'b1;
        sqe_cnt <= 9'h000;
      end else if (sqe_run) begin
        if (sqe_cnt == SQE_END - 9'h001 || mode.full_duplex) begin
          sqe_run <= 1'b0;
        end
        sqe_cnt <= sqe_cnt + 9'h001;
      end
    end
  end

  // =====================================================================
  // receive path from the line domain

  logic dec_evt;
  phy_pkg::rx_word_t dec_word;
  logic dec_active;
  logic rx_evt;
  phy_pkg::rx_word_t rx_word;
  logic [1:0] act_sync;
  logic rx_act;
  logic pending;
  logic loopback;

  line_rx_decoder u_rx_dec (
    .line_clk(line_clk),
    .arst_n(arst_n),
    .line_rx_positive(line_rx_positive),
    .line_rx_negative(line_rx_negative),
    .speed100(mode.speed100),
    .word_evt(dec_evt),
    .word(dec_word),
    .active(dec_active)
  );

  word_crossing #(
    .WIDTH($bits(phy_pkg::rx_word_t))
  ) u_rx_cross (
    .src_clk(line_clk),
    .src_arst_n(arst_n),
    .src_evt(dec_evt),
    .src_word(dec_word),
    .dst_clk(clk),
    .dst_arst_n(arst_n),
    .dst_evt(rx_evt),
    .dst_word(rx_word)
  );

  assign rx_act = act_sync[1];
  // echo only in 10M half duplex while the line is quiet
  assign loopback = ~mode.speed100 & ~mode.full_duplex & tx_s.tx_en & ~rx_act;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_sync <= 2'h0;
      pending <= 1'b0;
    end else begin
      act_sync <= {act_sync[0], dec_active};
      if (rx_evt) begin
        pending <= 1'b1;
      end else if (nib_tick) begin
        pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mii_rxd <= 4'h0;
      mii_rx_dv <= 1'b0;
      mii_rx_er <= 1'b0;
    end else if (iso) begin
      mii_rxd <= 4'h0;
      mii_rx_dv <= 1'b0;
      mii_rx_er <= 1'b0;
    end else if (nib_tick) begin
      if (loopback) begin
        mii_rxd <= tx_s.txd;
        mii_rx_dv <= 1'b1;
        mii_rx_er <= tx_s.tx_er;
      end else if (pending) begin
        mii_rxd <= rx_word.data;
        mii_rx_dv <= 1'b1;
        mii_rx_er <= rx_word.err;
      end else begin
        mii_rx_dv <= 1'b0;
        mii_rx_er <= 1'b0;
      end
    end
  end

  // =====================================================================
  // carrier sense and collision

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mii_crs <= 1'b0;
      mii_col <= 1'b0;
      mii_oe <= 1'b0;
    end else begin
      mii_oe <= ~iso;
      if (iso) begin
        mii_crs <= 1'b0;
        mii_col <= 1'b0;
      end else if (mode.full_duplex) begin
        mii_crs <= rx_act;
        mii_col <= 1'b0;
      end else begin
        mii_crs <= rx_act | tx_s.tx_en;
        mii_col <= (rx_act & tx_s.tx_en) | sqe_on;
      end
    end
  end

endmodule : phy_mii_duplex_autoneg_ctrl
`default_nettype wire

//--- dv/phy_ctrl_chk.sv
// port assertions for the phy control block
// assumes it is bound into phy_mii_duplex_autoneg_ctrl, clk domain only
`default_nettype none
module phy_ctrl_chk (
  // system
  input wire logic clk,
  input wire logic arst_n,
  // inputs
  input wire phy_pkg::cfg_pins_t cfg_in,
  input wire phy_pkg::mii_tx_t mii_tx,
  // outputs
  input wire logic mii_tx_clk,
  input wire logic mii_rx_clk,
  input wire logic mii_crs,
  input wire logic mii_col,
  input wire logic mii_oe,
  input wire logic line_tx_oe,
  input wire logic autoneg_enabled,
  input wire logic link_speed100,
  input wire logic link_full_duplex
);
  // ====================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  iso_quiet_a: assert property (!mii_oe |-> !mii_tx_clk && !mii_crs && !mii_col)
    else $error("mii active while isolated");
  oe_pair_a: assert property (mii_oe == line_tx_oe)
    else $error("mii and line enables differ");
  clk_same_a: assert property (mii_tx_clk == mii_rx_clk)
    else $error("mii clocks differ");
  rate_100_a: assert property (disable iff (!arst_n || !link_speed100)
    $rose(mii_tx_clk) |-> mii_tx_clk [*5] ##1 !mii_tx_clk) else $error("100M clock rate");
  fd_no_col_a: assert property (link_full_duplex && $past(link_full_duplex, 3) |-> !mii_col)
    else $error("collision in full duplex");
  hd_crs_a: assert property ((mii_oe && !link_full_duplex && mii_tx.tx_en) [*4]
    |-> ##[0:1] mii_crs) else $error("no carrier while sending");
  sqe_col_a: assert property (!link_speed100 && !link_full_duplex
    && $fell(mii_tx.tx_en) |-> ##[245:262] mii_col) else $error("no sqe test pulse");
  an_source_a: assert property ($stable(cfg_in) [*6] |-> autoneg_enabled ==
    (cfg_in.config_source_select ? cfg_in.sw_autoneg_enable : cfg_in.autoneg_select_pin))
    else $error("wrong negotiation source");
  sqe_seen_c: cover property ($rose(mii_col));
  crs_seen_c: cover property ($rose(mii_crs));
  oe_seen_c: cover property ($rose(mii_oe));
endmodule : phy_ctrl_chk
bind phy_mii_duplex_autoneg_ctrl phy_ctrl_chk chk (.clk, .arst_n, .cfg_in, .mii_tx,
  .mii_tx_clk, .mii_rx_clk, .mii_crs, .mii_col, .mii_oe, .line_tx_oe, .autoneg_enabled,
  .link_speed100, .link_full_duplex);
`default_nettype wire

//--- dv/mac_model.sv
// mac transmit model: preamble, delimiter, then counting nibbles
// assumes tx_clk comes from the phy and stays low while isolated
`default_nettype none
module mac_model (
  // control
  input wire logic go,
  input wire logic [7:0] len,
  output logic busy,
  // mii transmit
  input wire logic tx_clk,
  output var phy_pkg::mii_tx_t tx
);
  logic [7:0] cnt;
  initial begin
    busy = 1'b0;
    cnt = 8'h00;
    tx = '0;
  end
  // changes only after the phy clock rises
  always @(posedge tx_clk) begin
    if (!busy && go) begin
      busy <= 1'b1;
      cnt <= 8'h01;
      tx <= {4'h5, 1'b1, 1'b0};
    end else if (busy && cnt != len) begin
      cnt <= cnt + 8'h01;
      tx <= {cnt < 8'h0f ? 4'h5 : cnt == 8'h0f ? 4'hd : cnt[3:0], 1'b1, 1'b0};
    end else begin
      busy <= 1'b0;
      tx <= {~tx.txd, 1'b0, 1'b0};
    end
  end
endmodule : mac_model
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the phy control block
// assumes design, checker and mac_model compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic line_clk = 1'b0;
  logic arst_n = 1'b0;
  logic go = 1'b0;
  logic busy;
  phy_pkg::cfg_pins_t cfg_in = '0;
  phy_pkg::mii_tx_t mii_tx;
  logic tx_clk, crs, col, mii_oe, tx_p, tx_n, tx_oe, an_en, spd, fd, dv, er;
  logic [3:0] rxd;
  logic rx_p = 1'b0;
  int bad_count = 0;
  int n_compared = 0;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED at %0t: value mismatch", $time); end end
  always #2 clk = ~clk;
  initial begin
    #1.3;
    forever #32 line_clk = ~line_clk;
  end
  phy_mii_duplex_autoneg_ctrl #(.POR_HOLD_CYCLES(8), .LOCAL_ABILITIES(4'hf)) dut (
    .clk, .arst_n, .cfg_in, .mii_tx, .mii_tx_clk(tx_clk), .mii_rx_clk(), .mii_rxd(rxd),
    .mii_rx_dv(dv), .mii_rx_er(er), .mii_crs(crs), .mii_col(col), .mii_oe, .line_clk,
    .line_rx_positive(rx_p), .line_rx_negative(1'b0), .line_tx_positive(tx_p),
    .line_tx_negative(tx_n), .line_tx_oe(tx_oe), .autoneg_enabled(an_en),
    .link_speed100(spd), .link_full_duplex(fd));
  mac_model mac (.go, .len(8'h18), .busy, .tx_clk, .tx(mii_tx));
  // ====================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic setcfg(input logic [11:0] v);
    @(posedge clk);
    cfg_in <= v;
    cyc(8);
  endtask : setcfg
  task automatic till(input logic v, output int n);
    n = 0;
    while (tx_clk !== v && n < 300) begin
      cyc(1);
      n++;
    end
  endtask : till
  task automatic period(output int p);
    int a;
    int b;
    till(1'b0, a);
    till(1'b1, a);
    till(1'b0, a);
    till(1'b1, b);
    p = a + b;
  endtask : period
  // ====================
  // scenarios
  task automatic t_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    cyc(10);
    `CHK({mii_oe, tx_oe, tx_clk}, 3'h0)
    @(posedge clk);
    arst_n <= 1'b1;
    cyc(4);
    `CHK({mii_oe, tx_oe, tx_p, tx_n}, 4'h0)
    cyc(8);
    `CHK({mii_oe, tx_oe}, 2'h3)
  endtask : t_reset
  task automatic t_source;
    logic [2:0] i;
    for (int j = 0; j < 8; j++) begin
      i = 3'(j);
      setcfg({i, 9'h000});
      `CHK(an_en, i[2] ? i[0] : i[1])
    end
  endtask : t_source
  task automatic t_autoneg;
    logic [3:0] ab;
    for (int j = 0; j < 16; j++) begin
      ab = 4'(j);
      setcfg({8'h41, ab});
      `CHK({spd, fd}, ab[3] ? 2'h3 : ab[2] ? 2'h2 : ab[1] ? 2'h1 : 2'h0)
    end
  endtask : t_autoneg
  task automatic t_rate;
    int p;
    setcfg(12'h180);
    `CHK({spd, fd}, 2'h3)
    period(p);
    `CHK(p, 10)
    setcfg(12'h820);
    `CHK({spd, fd}, 2'h1)
    period(p);
    `CHK(p, 100)
  endtask : t_rate
  task automatic t_frame(input logic [11:0] v, input logic crs_e, input logic sqe_e);
    int k;
    int act;
    logic c_mid;
    logic col_f;
    logic sqe;
    logic [5:0] e_mid;
    e_mid = 6'h00;
    act = 0;
    c_mid = 1'b0;
    col_f = 1'b0;
    sqe = 1'b0;
    setcfg(v);
    @(posedge clk);
    go <= 1'b1;
    for (k = 0; k < 400 && busy !== 1'b1; k++) cyc(1);
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 5000 && busy === 1'b1; k++) begin
      cyc(1);
      act += int'(tx_p | tx_n);
      col_f |= col;
      if (k == 200) begin
        c_mid = crs;
        e_mid = {dv, er, dv ? rxd : 4'h0};
      end
    end
    for (k = 0; k < 700; k++) begin
      cyc(1);
      sqe |= col;
    end
    `CHK(c_mid, crs_e)
    `CHK(col_f, 1'b0)
    `CHK(act > 0, 1'b1)
    `CHK(sqe, sqe_e)
    `CHK(e_mid, sqe_e ? 6'h25 : 6'h00)
  endtask : t_frame
  task automatic t_rx(input logic [11:0] v, input logic col_e);
    setcfg(v);
    @(posedge clk);
    rx_p <= 1'b1;
    cyc(40);
    `CHK({crs, col}, 2'h2)
    @(posedge clk);
    go <= 1'b1;
    cyc(300);
    `CHK(col, col_e)
    @(posedge clk);
    go <= 1'b0;
    rx_p <= 1'b0;
    cyc(3000);
  endtask : t_rx
  // ====================
  // sequence and verdict
  task automatic results;
    $display("mismatches %0d of %0d compared", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    t_reset();
    t_source();
    t_autoneg();
    t_rate();
    t_frame(12'h100, 1'b1, 1'b0);
    t_frame(12'h180, 1'b0, 1'b0);
    t_frame(12'h000, 1'b1, 1'b1);
    t_frame(12'h080, 1'b0, 1'b0);
    t_rx(12'h080, 1'b0);
    t_rx(12'h000, 1'b1);
    t_reset();
    t_frame(12'h180, 1'b0, 1'b0);
    results();
  end
  initial begin
    #200us;
    bad_count++;
    results();
  end
endmodule : testbench
`default_nettype wire
